// >>> core/pcat_consts.vh
// constants for the counter/timer time base with shared interrupt request
//
// Notes on behaviour
// - 16-bit up-counter seen as two bytes
// - low-byte read snapshots high byte for next read
// - reads never disturb the counting
// - 3-bit field selects the tick source
// - count synchronised falling edges of count pin
// - oscillator divide-by-8 ticks synchronised to clock
// - wrap from all ones sets main overflow
// - main overflow requests only when enabled
// - main overflow cleared only by software
// - idle-halt clear keeps counting during idle
// - all events merge into one request
// - partial overflow from bit eight to eleven
// - one event flag per channel
// - flags set regardless of their enables
// - request is OR of enabled flags
// - request needs global and module enables
// - low byte read/write, resets to zero
`ifndef PCAT_CONSTS_VH
`define PCAT_CONSTS_VH

`define PCAT_AW          8
`define PCAT_NCH         4
// register byte offsets
`define PCAT_A_CNT_LO    8'h00
`define PCAT_A_CNT_HI    8'h04
`define PCAT_A_MODE      8'h08
`define PCAT_A_STATUS    8'h0C
`define PCAT_A_CLEAR     8'h10
`define PCAT_A_IRQ_EN    8'h14
// mode register fields
`define PCAT_M_SRC       2:0
`define PCAT_M_IDLE      3
`define PCAT_M_PSEL      5:4
`define PCAT_M_GIE       6
`define PCAT_M_MIE       7
`define PCAT_MODE_RST    8'h00
// status / clear / enable layout
`define PCAT_S_MAIN      0
`define PCAT_S_PART      1
`define PCAT_S_CH        5:2
`define PCAT_EV_W        6
`define PCAT_EV_RST      6'h00
// tick source encodings
`define PCAT_SRC_DIV12   3'h0
`define PCAT_SRC_DIV4    3'h1
`define PCAT_SRC_T0      3'h2
`define PCAT_SRC_PIN     3'h3
`define PCAT_SRC_SYS     3'h4
`define PCAT_SRC_XOSC    3'h5
`define PCAT_SRC_LFO     3'h6
// divider terminal counts
`define PCAT_PRE_LAST    4'hB
`define PCAT_DIV4_LAST   2'h3
`define PCAT_OSC_LAST    3'h7
`define PCAT_CNT_ALL1    16'hFFFF
`define PCAT_CNT_RST     16'h0000
`define PCAT_PART_BASE   8'hFF
// axi responses
`define PCAT_RESP_OK     2'h0
`define PCAT_RESP_SLVERR 2'h2

`endif

// >>> core/pcat_top.v
// counter/timer time base with snapshot reads, overflow flags and one request
`timescale 1ns/1ns
`default_nettype none
`include "pcat_consts.vh"

module pcat_top (
    input  wire                     CLOCK,
    input  wire                     NRST,
    // axi4-lite slave
    input  wire [`PCAT_AW-1:0]      AWADDR,
    input  wire                     AWVALID,
    output reg                      AWREADY,
    input  wire [31:0]              WDATA,
    input  wire [3:0]               WSTRB,
    input  wire                     WVALID,
    output reg                      WREADY,
    output reg  [1:0]               BRESP,
    output reg                      BVALID,
    input  wire                     BREADY,
    input  wire [`PCAT_AW-1:0]      ARADDR,
    input  wire                     ARVALID,
    output reg                      ARREADY,
    output reg  [31:0]              RDATA,
    output reg  [1:0]               RRESP,
    output reg                      RVALID,
    input  wire                     RREADY,
    // time base sources, idle input and channel events
    input  wire                     TIMER0_OVF,
    input  wire                     EXT_COUNT_PIN,
    input  wire                     EXT_OSC_CLK,
    input  wire                     LFO_CLK,
    input  wire                     CPU_IDLE,
    input  wire [`PCAT_NCH-1:0]     CHANNEL_EVENT,
    // shared request
    output reg                      IRQ
);

// =============================================================
// synchronisers and edge detect for outside signals
// =============================================================
// bit 0 count pin, bit 1 external oscillator, bit 2 low-frequency oscillator
wire [2:0] async_in;
wire [2:0] rise_ev;
wire [2:0] fall_ev;
assign async_in = {LFO_CLK, EXT_OSC_CLK, EXT_COUNT_PIN};

genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
        reg s1_r;
        reg s2_r;
        reg s3_r;
        always @(posedge CLOCK or negedge NRST) begin
            if (!NRST) begin
                s1_r <= 1'b0;
                s2_r <= 1'b0;
                s3_r <= 1'b0;
            end else begin
                s1_r <= async_in[gi];
                s2_r <= s1_r;
                s3_r <= s2_r;
            end
        end
        // edge detectors look only at the settled stages
        assign rise_ev[gi] = s2_r & ~s3_r;
        assign fall_ev[gi] = ~s2_r & s3_r;
    end
endgenerate

// =============================================================
// oscillator divide-by-8, counted after synchronisation
// =============================================================
wire [1:0] osc_tick;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_odiv
        reg [2:0] div_r;
        always @(posedge CLOCK or negedge NRST) begin
            if (!NRST) begin
                div_r <= 3'h0;
            end else if (rise_ev[gi+1]) begin
                div_r <= div_r + 3'h1;
            end
        end
        assign osc_tick[gi] = rise_ev[gi+1] & (div_r == `PCAT_OSC_LAST);
    end
endgenerate

// =============================================================
// system clock prescaler: divide by 12, divide by 4 from same count
// =============================================================
reg  [3:0] pre_r;
wire       pre_wrap;
wire       pre_q4;
assign pre_wrap = (pre_r == `PCAT_PRE_LAST);
// div4 shares the div12 count so both taps stay phase-locked
assign pre_q4   = (pre_r[1:0] == `PCAT_DIV4_LAST);

always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
        pre_r <= 4'h0;
    end else if (pre_wrap) begin
        pre_r <= 4'h0;
    end else begin
        pre_r <= pre_r + 4'h1;
    end
end

// =============================================================
// registers
// =============================================================
reg  [15:0]          cnt_r;
reg  [7:0]           snap_r;
reg  [7:0]           mode_r;
reg  [`PCAT_EV_W-1:0] stat_r;
reg  [`PCAT_EV_W-1:0] ien_r;

wire [2:0] tick_source_sel;
wire       idle_halt_ctl;
wire [1:0] part_sel;
wire       global_irq_en;
wire       module_irq_en;
assign tick_source_sel = mode_r[`PCAT_M_SRC];
assign idle_halt_ctl   = mode_r[`PCAT_M_IDLE];
assign part_sel        = mode_r[`PCAT_M_PSEL];
assign global_irq_en   = mode_r[`PCAT_M_GIE];
assign module_irq_en   = mode_r[`PCAT_M_MIE];

// =============================================================
// tick selection
// =============================================================
reg src_tick;
always @* begin
    case (tick_source_sel)
        `PCAT_SRC_DIV12: src_tick = pre_wrap;
        `PCAT_SRC_DIV4:  src_tick = pre_q4;
        `PCAT_SRC_T0:    src_tick = TIMER0_OVF;
        `PCAT_SRC_PIN:   src_tick = fall_ev[0];
        `PCAT_SRC_SYS:   src_tick = 1'b1;
        `PCAT_SRC_XOSC:  src_tick = osc_tick[0];
        `PCAT_SRC_LFO:   src_tick = osc_tick[1];
        default:         src_tick = 1'b0;
    endcase
end

// idle only stops the count when the halt bit is set
wire tick;
assign tick = src_tick & ~(idle_halt_ctl & CPU_IDLE);

// =============================================================
// axi4-lite write channel
// =============================================================
reg  [`PCAT_AW-1:0] aw_addr_r;
reg                 aw_have_r;
reg  [31:0]         w_data_r;
reg  [3:0]          w_strb_r;
reg                 w_have_r;
wire                wr_do;
wire                wr_lane0;
wire                b_done;
assign b_done   = BVALID & BREADY;
assign wr_do    = aw_have_r & w_have_r & ~BVALID;
assign wr_lane0 = wr_do & w_strb_r[0];

always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
        AWREADY   <= 1'b1;
        WREADY    <= 1'b1;
        BVALID    <= 1'b0;
        BRESP     <= `PCAT_RESP_OK;
        aw_addr_r <= {`PCAT_AW{1'b0}};
        aw_have_r <= 1'b0;
        w_data_r  <= 32'h0000_0000;
        w_strb_r  <= 4'h0;
        w_have_r  <= 1'b0;
    end else begin
        if (AWVALID && AWREADY) begin
            aw_addr_r <= AWADDR;
            aw_have_r <= 1'b1;
            AWREADY   <= 1'b0;
        end
        if (WVALID && WREADY) begin
            w_data_r <= WDATA;
            w_strb_r <= WSTRB;
            w_have_r <= 1'b1;
            WREADY   <= 1'b0;
        end
        if (wr_do) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            BVALID    <= 1'b1;
            case (aw_addr_r)
                `PCAT_A_CNT_LO, `PCAT_A_CNT_HI, `PCAT_A_MODE,
                `PCAT_A_STATUS, `PCAT_A_CLEAR, `PCAT_A_IRQ_EN:
                    BRESP <= `PCAT_RESP_OK;
                default:
                    BRESP <= `PCAT_RESP_SLVERR;
            endcase
        end
        if (b_done) begin
            BVALID  <= 1'b0;
            AWREADY <= 1'b1;
            WREADY  <= 1'b1;
        end
    end
end

wire wr_lo;
wire wr_hi;
wire wr_mode;
wire wr_clr;
wire wr_ien;
assign wr_lo   = wr_lane0 & (aw_addr_r == `PCAT_A_CNT_LO);
assign wr_hi   = wr_lane0 & (aw_addr_r == `PCAT_A_CNT_HI);
assign wr_mode = wr_lane0 & (aw_addr_r == `PCAT_A_MODE);
assign wr_clr  = wr_lane0 & (aw_addr_r == `PCAT_A_CLEAR);
assign wr_ien  = wr_lane0 & (aw_addr_r == `PCAT_A_IRQ_EN);

// =============================================================
// axi4-lite read channel
// =============================================================
wire rd_take;
wire rd_lo;
wire rd_done;
assign rd_done = RVALID & RREADY;
assign rd_take = ARVALID & ARREADY;
assign rd_lo   = rd_take & (ARADDR == `PCAT_A_CNT_LO);

reg [31:0] rd_data;
reg [1:0]  rd_resp;
always @* begin
    rd_data = 32'h0000_0000;
    rd_resp = `PCAT_RESP_OK;
    case (ARADDR)
        `PCAT_A_CNT_LO: rd_data[7:0] = cnt_r[7:0];
        `PCAT_A_CNT_HI: rd_data[7:0] = snap_r;
        `PCAT_A_MODE:   rd_data[7:0] = mode_r;
        `PCAT_A_STATUS: rd_data[`PCAT_EV_W-1:0] = stat_r;
        `PCAT_A_CLEAR:  rd_data = 32'h0000_0000;
        `PCAT_A_IRQ_EN: rd_data[`PCAT_EV_W-1:0] = ien_r;
        default:        rd_resp = `PCAT_RESP_SLVERR;
    endcase
end

always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
        ARREADY <= 1'b1;
        RVALID  <= 1'b0;
        RDATA   <= 32'h0000_0000;
        RRESP   <= `PCAT_RESP_OK;
    end else begin
        if (rd_take) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RDATA   <= rd_data;
            RRESP   <= rd_resp;
        end else if (rd_done) begin
            RVALID  <= 1'b0;
            ARREADY <= 1'b1;
        end
    end
end

// =============================================================
// snapshot of the high byte
// =============================================================
// a high-byte read alone returns whatever the last low-byte read caught
always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
        snap_r <= 8'h00;
    end else if (rd_lo) begin
        snap_r <= cnt_r[15:8];
    end
end

// =============================================================
// counter
// =============================================================
// reads touch nothing here; a software byte write beats a tick that cycle
wire [15:0] cnt_inc;
assign cnt_inc = cnt_r + 16'h0001;

reg [15:0] cnt_nxt;
always @* begin
    cnt_nxt = cnt_r;
    if (wr_lo) begin
        cnt_nxt[7:0] = w_data_r[7:0];
    end else if (wr_hi) begin
        cnt_nxt[15:8] = w_data_r[7:0];
    end else if (tick) begin
        cnt_nxt = cnt_inc;
    end
end

always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
        cnt_r <= `PCAT_CNT_RST;
    end else begin
        cnt_r <= cnt_nxt;
    end
end

// =============================================================
// event flags
// =============================================================
wire cnt_adv;
wire main_set;
wire part_set;
assign cnt_adv  = tick & ~wr_lo & ~wr_hi;
assign main_set = cnt_adv & (cnt_r == `PCAT_CNT_ALL1);

// carry into bit 8..11: all bits below the chosen one are ones
wire [15:0] part_mask;
assign part_mask = {4'h0, ~(4'hF << part_sel), `PCAT_PART_BASE};
assign part_set  = cnt_adv & ((cnt_r & part_mask) == part_mask);

wire [`PCAT_EV_W-1:0] ev_set;
assign ev_set = {CHANNEL_EVENT, part_set, main_set};

reg [`PCAT_EV_W-1:0] stat_nxt;
always @* begin
    stat_nxt = stat_r;
    if (wr_clr) begin
        stat_nxt = stat_r & ~w_data_r[`PCAT_EV_W-1:0];
    end
    // set wins over a clear in the same cycle; nothing clears on service
    stat_nxt = stat_nxt | ev_set;
end

always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
        stat_r <= `PCAT_EV_RST;
    end else begin
        stat_r <= stat_nxt;
    end
end

always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
        ien_r <= `PCAT_EV_RST;
    end else if (wr_ien) begin
        ien_r <= w_data_r[`PCAT_EV_W-1:0];
    end
end

always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
        mode_r <= `PCAT_MODE_RST;
    end else if (wr_mode) begin
        mode_r <= w_data_r[7:0];
    end
end

// =============================================================
// shared interrupt request
// =============================================================
wire [`PCAT_EV_W-1:0] ev_armed;
wire                  mod_req;
wire                  irq_nxt;
assign ev_armed = stat_r & ien_r;
assign mod_req  = |ev_armed;
// the core sees the request only with both enables set
assign irq_nxt  = global_irq_en & module_irq_en & mod_req;

always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
        IRQ <= 1'b0;
    end else begin
        IRQ <= irq_nxt;
    end
end

endmodule
`default_nettype wire

// >>> testbench/pcat_chk.sv
// bus and request checks for the counter/timer block
`timescale 1ns/1ns
`default_nettype none
`include "pcat_consts.vh"
module pcat_chk (
    input wire logic        CLOCK,
    input wire logic        NRST,
    input wire logic        AWVALID,
    input wire logic        AWREADY,
    input wire logic        WVALID,
    input wire logic        WREADY,
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic [7:0]  ARADDR,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0]  RRESP,
    input wire logic        RVALID,
    input wire logic        RREADY,
    input wire logic        IRQ
);
    // =========================================
    // properties
    wire w_take = WVALID & WREADY;
    wire ar_take = ARVALID & ARREADY;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    property p_ar_take; ar_take |=> RVALID && !ARREADY; endproperty
    a_ar_take: assert property (p_ar_take) else $error("read not answered");
    property p_r_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data moved");
    property p_r_done; RVALID && RREADY |=> !RVALID && ARREADY; endproperty
    a_r_done: assert property (p_r_done) else $error("read not closed");
    property p_w_take;
        AWVALID && AWREADY && w_take |=> !AWREADY && !WREADY ##1 BVALID;
    endproperty
    a_w_take: assert property (p_w_take) else $error("write not answered");
    property p_b_done; BVALID && BREADY |=> !BVALID && AWREADY && WREADY; endproperty
    a_b_done: assert property (p_b_done) else $error("write not closed");
    property p_unmapped;
        ar_take && ARADDR > 8'h14 |=> RRESP == `PCAT_RESP_SLVERR && RDATA == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_clear_rd; ar_take && ARADDR == `PCAT_A_CLEAR |=> RDATA == 32'h0; endproperty
    a_clear_rd: assert property (p_clear_rd) else $error("clear read nonzero");
    // a request only drops through software, never by itself
    property p_irq_fall;
        $fell(IRQ) |-> $past(w_take, 1) || $past(w_take, 2) || $past(w_take, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("request dropped alone");
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the counter/timer block
`timescale 1ns/1ns
`default_nettype none
`include "pcat_consts.vh"
module tb_top;
    logic        CLOCK = 1'b0, NRST = 1'b0, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
    logic        ARVALID = 1'b0, RREADY = 1'b0, TIMER0_OVF = 1'b0, EXT_COUNT_PIN = 1'b1;
    logic        EXT_OSC_CLK = 1'b0, LFO_CLK = 1'b0, CPU_IDLE = 1'b0;
    logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, rd;
    logic [3:0]  WSTRB = 4'h0, CHANNEL_EVENT = 4'h0;
    logic [1:0]  rsp;
    wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
    wire  [1:0]  BRESP, RRESP;
    wire  [31:0] RDATA;
    int          n_mismatch = 0, tests_run = 0, i, p;
    // =========================================
    // clocks and device
    always #25 CLOCK = ~CLOCK;
    // oscillators free run, unrelated to the system clock
    always #65 EXT_OSC_CLK = ~EXT_OSC_CLK;
    always #85 LFO_CLK = ~LFO_CLK;
    pcat_top dut_u (.CLOCK(CLOCK), .NRST(NRST), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .TIMER0_OVF(TIMER0_OVF), .EXT_COUNT_PIN(EXT_COUNT_PIN), .EXT_OSC_CLK(EXT_OSC_CLK),
        .LFO_CLK(LFO_CLK), .CPU_IDLE(CPU_IDLE), .CHANNEL_EVENT(CHANNEL_EVENT), .IRQ(IRQ));
    // =========================================
    // tasks
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLOCK);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
        @(posedge CLOCK);
        AWADDR <= a;
        WDATA <= {24'h000000, d};
        WSTRB <= s;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge CLOCK);
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
        end while (!BVALID);
        rsp = BRESP;
        BREADY <= 1'b0;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        wr(a, d, 4'hF);
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge CLOCK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge CLOCK);
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
        end while (!RVALID);
        rd = RDATA;
        rsp = RRESP;
        RREADY <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        rdr(a);
        chk(nm, rd, e);
    endtask
    task automatic irqchk(input logic e);
        cyc(3);
        chk("irq", {31'h0, IRQ}, {31'h0, e});
    endtask
    // the reserved source is used to park the counter while it is loaded
    task automatic setcnt(input logic [15:0] v);
        wreg(`PCAT_A_MODE, 8'h07);
        wreg(`PCAT_A_CNT_LO, v[7:0]);
        wreg(`PCAT_A_CNT_HI, v[15:8]);
    endtask
    task automatic pulse;
        TIMER0_OVF <= 1'b1;
        @(posedge CLOCK);
        TIMER0_OVF <= 1'b0;
        cyc(3);
    endtask
    // window length includes bus latency, so only a band can be expected
    task automatic span(input string nm, input logic [7:0] m, input int mn, input int mx);
        setcnt(16'h0000);
        wreg(`PCAT_A_MODE, m);
        cyc(240);
        wreg(`PCAT_A_MODE, 8'h07);
        rdr(`PCAT_A_CNT_LO);
        chk(nm, {31'h0, rd >= mn && rd <= mx}, 32'h1);
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        n_mismatch++;
        close_out;
    end
    // =========================================
    // scenarios
    initial begin
        cyc(2);
        NRST <= 1'b1;
        for (i = 0; i < 6; i++) rchk("reset value", 8'(i * 4), 32'h0);
        rdr(8'h20);
        chk("unmapped read", {30'h0, rsp}, {30'h0, `PCAT_RESP_SLVERR});
        wreg(8'h20, 8'hAA);
        chk("unmapped write", {30'h0, rsp}, {30'h0, `PCAT_RESP_SLVERR});
        setcnt(16'h12FF);
        wreg(`PCAT_A_MODE, 8'h02);
        rchk("low byte", `PCAT_A_CNT_LO, 32'hFF);
        pulse;
        rchk("snapshot", `PCAT_A_CNT_HI, 32'h12);
        rchk("low after tick", `PCAT_A_CNT_LO, 32'h00);
        rchk("high after tick", `PCAT_A_CNT_HI, 32'h13);
        wreg(`PCAT_A_MODE, 8'h07);
        pulse;
        rchk("reserved hold", `PCAT_A_CNT_LO, 32'h00);
        wr(`PCAT_A_CNT_LO, 8'h55, 4'hE);
        rchk("no strobe", `PCAT_A_CNT_LO, 32'h00);
        setcnt(16'hFFFF);
        wreg(`PCAT_A_MODE, 8'h02);
        pulse;
        rchk("wrap", `PCAT_A_CNT_LO, 32'h00);
        rchk("wrap flags", `PCAT_A_STATUS, 32'h03);
        wreg(`PCAT_A_MODE, 8'hC2);
        irqchk(1'b0);
        wreg(`PCAT_A_IRQ_EN, 8'h01);
        irqchk(1'b1);
        wreg(`PCAT_A_MODE, 8'h82);
        irqchk(1'b0);
        wreg(`PCAT_A_MODE, 8'h42);
        irqchk(1'b0);
        wreg(`PCAT_A_MODE, 8'hC2);
        cyc(20);
        irqchk(1'b1);
        wreg(`PCAT_A_CLEAR, 8'h01);
        rchk("clear main", `PCAT_A_STATUS, 32'h02);
        irqchk(1'b0);
        wreg(`PCAT_A_IRQ_EN, 8'h02);
        irqchk(1'b1);
        wreg(`PCAT_A_CLEAR, 8'h3F);
        for (i = 0; i < 4; i++) begin
            CHANNEL_EVENT <= 4'(1 << i);
            @(posedge CLOCK);
            CHANNEL_EVENT <= 4'h0;
            rchk("channel flag", `PCAT_A_STATUS, 32'(4 << i));
            irqchk(1'b0);
            wreg(`PCAT_A_IRQ_EN, 8'(4 << i));
            irqchk(1'b1);
            wreg(`PCAT_A_CLEAR, 8'(4 << i));
        end
        wreg(`PCAT_A_IRQ_EN, 8'h00);
        for (p = 0; p < 4; p++) begin
            setcnt(16'((128 << p) - 1));
            wreg(`PCAT_A_MODE, 8'(p << 4 | 2));
            wreg(`PCAT_A_CLEAR, 8'h3F);
            pulse;
            rchk("partial below", `PCAT_A_STATUS, 32'h0);
            setcnt(16'((256 << p) - 1));
            wreg(`PCAT_A_MODE, 8'(p << 4 | 2));
            pulse;
            rchk("partial flag", `PCAT_A_STATUS, 32'h2);
        end
        setcnt(16'h0000);
        wreg(`PCAT_A_MODE, 8'h03);
        repeat (3) begin
            EXT_COUNT_PIN <= 1'b0;
            cyc(6);
            EXT_COUNT_PIN <= 1'b1;
            cyc(6);
        end
        wreg(`PCAT_A_MODE, 8'h07);
        rchk("pin edges", `PCAT_A_CNT_LO, 32'h03);
        span("div12", 8'h00, 19, 22);
        span("div4", 8'h01, 59, 63);
        span("sysclk", 8'h04, 240, 252);
        span("ext osc", 8'h05, 10, 13);
        span("lfo", 8'h06, 7, 10);
        CPU_IDLE <= 1'b1;
        span("idle halt", 8'h0C, 0, 0);
        span("idle run", 8'h04, 240, 252);
        close_out;
    end
endmodule
bind pcat_top pcat_chk chk_u (.CLOCK(CLOCK), .NRST(NRST), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .IRQ(IRQ));
`default_nettype wire
